// ==== design/rpsc_params.svh ====
`ifndef RPSC_PARAMS_SVH
`define RPSC_PARAMS_SVH
// ----------------------------------------------------------------
// fixed reset-time pin levels and strap defaults
// ----------------------------------------------------------------
`define RPSC_CPU_RST_LVL 1'h0
`define RPSC_SCK_LVL 1'h0
`define RPSC_ST_LVL 3'h0
`define RPSC_GNT_LVL 1'h1
`define RPSC_STB_COMP_LVL 1'h1
`define RPSC_BIT8_NORMAL_LVL 1'h0
`define RPSC_BIT8_ENH_LVL 1'h1
`define RPSC_STRAP_RESET 1'h1
`define RPSC_HA7_POS 7
`define RPSC_CLK_DIV 4
`endif

// ==== design/rpsc_pkg.sv ====
package rpsc_pkg;
    typedef enum logic [1:0] {
        RPSC_ST_RESET = 2'b01,
        RPSC_ST_RUN = 2'b10
    } rpsc_state_t;

    typedef struct packed {
        logic host_addr_bit7_strap;
        logic hub_link_enhanced;
    } rpsc_straps_t;

    typedef struct packed {
        logic chan_a_host_clock_out;
        logic chan_b_host_clock_out;
        logic chan_a_ref_clock_out;
        logic chan_b_ref_clock_out;
    } rpsc_clks_t;
endpackage : rpsc_pkg

// ==== design/rpsc_clkgen.sv ====
`timescale 1ns/100ps
`include "rpsc_params.svh"
// free-running clock outputs; deliberately not reset by system reset
module rpsc_clkgen
    import rpsc_pkg::*;
#(
    parameter int DIV = `RPSC_CLK_DIV
) (
    input wire logic clk,
    output rpsc_clks_t clks
);
    logic [7:0] cnt_r = 8'h00;
    logic lvl_r = 1'b0;

    always_ff @(posedge clk) begin
        if (cnt_r == 8'(DIV / 2 - 1)) begin
            cnt_r <= 8'h00;
            lvl_r <= ~lvl_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign clks = '{lvl_r, lvl_r, lvl_r, lvl_r};
endmodule : rpsc_clkgen

// ==== design/rpsc_top.sv ====
// Overview of operation
// - capture strap bit7 at reset release; pin tristated
// - memory channel host and reference clocks keep running in reset; serial clocks held low
// - sideband address inputs isolated during reset
// - fixed levels on listed outputs in reset
// - bus outputs tri-stated, inputs active, in reset
// - hub link pattern depends on mode strap
`timescale 1ns/100ps
`include "rpsc_params.svh"
module rpsc_top
    import rpsc_pkg::*;
#(
    parameter int SBA_W = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HUB_LINK_ENHANCED_STRAP_N,
    input wire logic HOST_ADDR_BIT7_STRAP_I,
    input wire logic [SBA_W-1:0] SBA_I,
    input wire logic FUNC_CPU_RESET_N,
    input wire logic FUNC_HOST_OUT,
    input wire logic FUNC_HOST_OE_N,
    input wire logic FUNC_MEM_OE_N,
    input wire logic FUNC_GFX_OE_N,
    input wire logic FUNC_HUB_OE_N,
    input wire logic FUNC_HUB_BIT8,
    input wire logic FUNC_HUB_STROBE_COMP,
    input wire logic [2:0] FUNC_GFX_STATUS,
    input wire logic FUNC_GFX_GRANT_N,
    input wire logic FUNC_SCK,
    output logic PROCESSOR_RESET_OUT_N,
    output logic HOST_ADDR_BIT7_OE_N,
    output logic HOST_ADDR_BIT7_O,
    output logic HOST_BUS_OE_N,
    output logic MEM_CHAN_OE_N,
    output logic GFX_HANDSHAKE_OE_N,
    output logic CHAN_A_SERIAL_CLOCK,
    output logic CHAN_B_SERIAL_CLOCK,
    output logic [2:0] GFX_STATUS,
    output logic GFX_GRANT_N,
    output logic HUB_LINK_FIRST_BIT8,
    output logic HUB_LINK_FIRST_STROBE_COMP,
    output logic HUB_LINK_LOW_OE_N,
    output logic HUB_LINK_OTHER_OE_N,
    output logic [SBA_W-1:0] SBA_INTERNAL,
    output rpsc_straps_t STRAPS,
    output rpsc_clks_t MEM_CLKS
);
    // ----------------------------------------------------------------
    // reset state
    // ----------------------------------------------------------------
    rpsc_state_t state_r;
    rpsc_state_t state_nxt;
    logic in_rst;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RPSC_ST_RESET: begin
                state_nxt = RPSC_ST_RUN;
            end
            RPSC_ST_RUN: begin
                state_nxt = RPSC_ST_RUN;
            end
            default: begin
                state_nxt = RPSC_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_r <= RPSC_ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // the first cycle after release still counts as reset: the straps are
    // latched then, and the sideband gate opens only once they are in
    assign in_rst = (state_r == RPSC_ST_RESET);

    // ----------------------------------------------------------------
    // straps: latched on the first clock after release, while the
    // board still holds the strap levels
    // ----------------------------------------------------------------
    logic strap_enh;

    // live mode strap; low on the pin selects the enhanced pattern
    assign strap_enh = ~HUB_LINK_ENHANCED_STRAP_N;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            STRAPS <= '{`RPSC_STRAP_RESET, 1'b0};
        end else if (in_rst) begin
            STRAPS.host_addr_bit7_strap <= HOST_ADDR_BIT7_STRAP_I;
            STRAPS.hub_link_enhanced <= strap_enh;
        end
    end

    // ----------------------------------------------------------------
    // processor reset
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            PROCESSOR_RESET_OUT_N <= `RPSC_CPU_RST_LVL;
        end else begin
            PROCESSOR_RESET_OUT_N <= FUNC_CPU_RESET_N;
        end
    end

    // ----------------------------------------------------------------
    // memory channel serial clocks
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CHAN_A_SERIAL_CLOCK <= `RPSC_SCK_LVL;
            CHAN_B_SERIAL_CLOCK <= `RPSC_SCK_LVL;
        end else begin
            CHAN_A_SERIAL_CLOCK <= FUNC_SCK;
            CHAN_B_SERIAL_CLOCK <= FUNC_SCK;
        end
    end

    // ----------------------------------------------------------------
    // graphics status and grant
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            GFX_STATUS <= `RPSC_ST_LVL;
        end else begin
            GFX_STATUS <= FUNC_GFX_STATUS;
        end
    end

    // grant is active low, so the high reset level means no grant
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            GFX_GRANT_N <= `RPSC_GNT_LVL;
        end else begin
            GFX_GRANT_N <= FUNC_GFX_GRANT_N;
        end
    end

    // ----------------------------------------------------------------
    // host bus: outputs float in reset, input buffers stay live
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HOST_BUS_OE_N <= 1'b1;
        end else begin
            HOST_BUS_OE_N <= FUNC_HOST_OE_N;
        end
    end

    // the strap pin joins the host enable on the strap edge itself, like the rest of the
    // host bus; the board level is sampled at that edge, just before the pin can drive
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HOST_ADDR_BIT7_OE_N <= 1'b1;
        end else begin
            HOST_ADDR_BIT7_OE_N <= FUNC_HOST_OE_N;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HOST_ADDR_BIT7_O <= 1'b0;
        end else begin
            HOST_ADDR_BIT7_O <= FUNC_HOST_OUT;
        end
    end

    // ----------------------------------------------------------------
    // memory channel and graphics handshake enables
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            MEM_CHAN_OE_N <= 1'b1;
        end else begin
            MEM_CHAN_OE_N <= FUNC_MEM_OE_N;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            GFX_HANDSHAKE_OE_N <= 1'b1;
        end else begin
            GFX_HANDSHAKE_OE_N <= FUNC_GFX_OE_N;
        end
    end

    // ----------------------------------------------------------------
    // first hub link: the reset pattern follows the live mode strap
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            if (strap_enh) begin
                HUB_LINK_FIRST_BIT8 <= `RPSC_BIT8_ENH_LVL;
            end else begin
                HUB_LINK_FIRST_BIT8 <= `RPSC_BIT8_NORMAL_LVL;
            end
        end else begin
            HUB_LINK_FIRST_BIT8 <= FUNC_HUB_BIT8;
        end
    end

    // in enhanced mode the complement strobe floats under the other-bits
    // enable, so its level only reaches the pin in normal mode
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HUB_LINK_FIRST_STROBE_COMP <= `RPSC_STB_COMP_LVL;
        end else begin
            HUB_LINK_FIRST_STROBE_COMP <= FUNC_HUB_STROBE_COMP;
        end
    end

    // low data bits float in both modes; the other data and strobe bits
    // are driven in normal mode and float in enhanced mode
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HUB_LINK_LOW_OE_N <= 1'b1;
            HUB_LINK_OTHER_OE_N <= strap_enh;
        end else begin
            HUB_LINK_LOW_OE_N <= FUNC_HUB_OE_N;
            HUB_LINK_OTHER_OE_N <= FUNC_HUB_OE_N;
        end
    end

    // ----------------------------------------------------------------
    // sideband isolation
    // ----------------------------------------------------------------
    // the raw reset term closes the gate before the state register has
    // caught up, so no pin toggle leaks through on the entry edge
    assign SBA_INTERNAL = (!RST_B || in_rst) ? '1 : SBA_I;

    // ----------------------------------------------------------------
    // memory channel host and reference clocks
    // ----------------------------------------------------------------
    // the divider has no reset on purpose: these clocks must keep
    // toggling through system reset
    rpsc_clkgen #(
        .DIV(`RPSC_CLK_DIV)
    ) u_rpsc_clkgen (
        .clk(CLK),
        .clks(MEM_CLKS)
    );
endmodule : rpsc_top

// ==== testbench/rpsc_top_checker.sv ====
`timescale 1ns/100ps
module rpsc_top_checker
    import rpsc_pkg::*;
#(
    parameter int SBA_W = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HUB_LINK_ENHANCED_STRAP_N,
    input wire logic HOST_ADDR_BIT7_STRAP_I,
    input wire logic FUNC_CPU_RESET_N,
    input wire logic PROCESSOR_RESET_OUT_N,
    input wire logic HOST_ADDR_BIT7_OE_N,
    input wire logic HOST_BUS_OE_N,
    input wire logic MEM_CHAN_OE_N,
    input wire logic GFX_HANDSHAKE_OE_N,
    input wire logic GFX_GRANT_N,
    input wire logic CHAN_A_SERIAL_CLOCK,
    input wire logic CHAN_B_SERIAL_CLOCK,
    input wire logic HUB_LINK_FIRST_BIT8,
    input wire logic HUB_LINK_FIRST_STROBE_COMP,
    input wire logic HUB_LINK_LOW_OE_N,
    input wire logic HUB_LINK_OTHER_OE_N,
    input wire logic [2:0] GFX_STATUS,
    input wire logic [SBA_W-1:0] SBA_INTERNAL,
    input wire rpsc_straps_t STRAPS,
    input wire rpsc_clks_t MEM_CLKS
);
    default clocking @(posedge CLK); endclocking
    AST_CPU_RST: assert property (
        !RST_B |=> !PROCESSOR_RESET_OUT_N
    ) else $error("cpu reset");
    AST_FIXED: assert property (
        !RST_B |=> {CHAN_A_SERIAL_CLOCK, CHAN_B_SERIAL_CLOCK, GFX_STATUS, GFX_GRANT_N,
        HUB_LINK_FIRST_STROBE_COMP} == 7'h03
    ) else $error("levels");
    AST_TRI: assert property (
        !RST_B |=> HOST_BUS_OE_N && MEM_CHAN_OE_N && GFX_HANDSHAKE_OE_N && HOST_ADDR_BIT7_OE_N
    ) else $error("tristate");
    AST_HUB_BIT8: assert property (
        !RST_B |=> HUB_LINK_FIRST_BIT8 == !$past(HUB_LINK_ENHANCED_STRAP_N)
    ) else $error("bit8");
    AST_HUB_OE: assert property (
        !RST_B |=> HUB_LINK_LOW_OE_N && (HUB_LINK_OTHER_OE_N == !$past(HUB_LINK_ENHANCED_STRAP_N))
    ) else $error("hub enables");
    AST_SBA_ISO: assert property (
        !RST_B |-> &SBA_INTERNAL
    ) else $error("sideband");
    AST_STRAP: assert property (
        $rose(RST_B) |=> STRAPS == {$past(HOST_ADDR_BIT7_STRAP_I),
        !$past(HUB_LINK_ENHANCED_STRAP_N)}
    ) else $error("strap");
    AST_RELEASE: assert property (
        disable iff (!RST_B) RST_B |=> PROCESSOR_RESET_OUT_N == $past(FUNC_CPU_RESET_N)
    ) else $error("release");
    AST_CLK_RUN: assert property (
        !RST_B |-> ##[1:8] $changed(MEM_CLKS)
    ) else $error("clk");
endmodule : rpsc_top_checker
bind rpsc_top rpsc_top_checker #(.SBA_W(SBA_W)) u_rpsc_top_checker (.*);

// ==== testbench/rpsc_strap_model.sv ====
`timescale 1ns/100ps
// board straps; the mode pin is pulled up, so normal mode unless pulled low
module rpsc_strap_model (
    input wire logic enh,
    input wire logic bit7,
    output logic strap_n,
    output logic bit7_o
);
    assign strap_n = !enh;
    assign bit7_o = bit7;
endmodule : rpsc_strap_model

// ==== testbench/tb_rpsc_top.sv ====
`timescale 1ns/100ps
module tb_rpsc_top;
    import rpsc_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic enh = 1'h0;
    logic b7 = 1'h0;
    logic sck = 1'h1;
    logic bit8 = 1'h0;
    logic fcpu = 1'h1;
    logic foe = 1'h0;
    logic fgnt = 1'h0;
    logic [2:0] fst = 3'h5;
    logic strap_n, b7_o;
    logic [7:0] sba = 8'h00;
    logic [7:0] sba_int;
    logic [2:0] st;
    logic cpu_n, oe_a, ha7, oe_h, oe_m, oe_g, oe_l, oe_o, b8, stb, gnt, sa, sb;
    rpsc_straps_t straps;
    rpsc_clks_t clks, c0;
    int fail_count = 0, total_checks = 0;
    always #5 clk = ~clk;
    rpsc_strap_model u_rpsc_strap_model (.enh(enh), .bit7(b7), .strap_n(strap_n), .bit7_o(b7_o));
    rpsc_top u_rpsc_top (.CLK(clk), .RST_B(rst_b), .HUB_LINK_ENHANCED_STRAP_N(strap_n),
        .HOST_ADDR_BIT7_STRAP_I(b7_o), .SBA_I(sba), .FUNC_CPU_RESET_N(fcpu),
        .FUNC_HOST_OUT(1'h1), .FUNC_HOST_OE_N(foe), .FUNC_MEM_OE_N(1'h0),
        .FUNC_GFX_OE_N(1'h0), .FUNC_HUB_OE_N(foe), .FUNC_HUB_BIT8(bit8),
        .FUNC_HUB_STROBE_COMP(1'h0), .FUNC_GFX_STATUS(fst), .FUNC_GFX_GRANT_N(fgnt),
        .FUNC_SCK(sck), .PROCESSOR_RESET_OUT_N(cpu_n), .HOST_ADDR_BIT7_OE_N(oe_a),
        .HOST_ADDR_BIT7_O(ha7), .HOST_BUS_OE_N(oe_h), .MEM_CHAN_OE_N(oe_m),
        .GFX_HANDSHAKE_OE_N(oe_g), .CHAN_A_SERIAL_CLOCK(sa), .CHAN_B_SERIAL_CLOCK(sb),
        .GFX_STATUS(st), .GFX_GRANT_N(gnt), .HUB_LINK_FIRST_BIT8(b8),
        .HUB_LINK_FIRST_STROBE_COMP(stb), .HUB_LINK_LOW_OE_N(oe_l),
        .HUB_LINK_OTHER_OE_N(oe_o), .SBA_INTERNAL(sba_int), .STRAPS(straps), .MEM_CLKS(clks));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic hold_reset(input logic m, input logic s);
        int n;
        n = 0;
        @(negedge clk);
        rst_b = 1'h0;
        enh = m;
        b7 = s;
        @(negedge clk);
        c0 = clks;
        repeat (9) begin
            @(negedge clk);
            sba = ~sba;
            if (clks !== c0) begin
                n++;
            end
            c0 = clks;
            #1 chk(sba_int, 16'hff);
        end
        // divide by four toggles every second cycle: four or five in nine
        chk(n >= 4, 1'h1);
        chk({cpu_n, sa, sb, st, gnt}, 16'h01);
        chk(stb, 1'h1);
        chk(oe_a, 1'h1);
        chk({oe_h, oe_m, oe_g}, 16'h7);
        chk({b8, oe_l, oe_o}, {m, 1'h1, m});
    endtask : hold_reset
    task automatic release_reset(input logic m, input logic s);
        @(negedge clk);
        rst_b = 1'h1;
        repeat (2) @(negedge clk);
        chk(straps, {s, m});
        chk({cpu_n, oe_a, ha7, oe_h, oe_m, oe_g}, {fcpu, foe, 1'h1, foe, 2'h0});
        chk({st, gnt, b8, stb, oe_l, oe_o}, {fst, fgnt, bit8, 1'h0, foe, foe});
        chk({sa, sb}, {sck, sck});
        chk(sba_int, sba);
        b7 = ~s;
        enh = ~m;
        @(negedge clk);
        chk(straps, {s, m});
    endtask : release_reset
    task automatic stop_test;
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            bit8 = i[0];
            sck = ~i[1];
            fcpu = ~i[0];
            foe = i[1];
            fgnt = i[0];
            fst = 3'(i + 2);
            hold_reset(i[0], i[1]);
            release_reset(i[0], i[1]);
        end
        stop_test();
    end
    // the scenarios need under a hundred cycles; the margin only catches a hang
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule : tb_rpsc_top
